/* hw/ctm_timer.sv */
// compact 10-bit count-up timer: modes, pin control, match flags, wishbone register slave
// assumes a single 250 MHz clock, synchronous reset, fH taken as the system clock
// and the sub clock arriving as a one-cycle tick from the same clock domain
//
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ctm_regs.svh"

module ctm_timer
   import ctm_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // clock sources
   input wire logic external_clock_pin_i,
   input wire logic sub_clock_tick_i,
   // timer pin
   output logic timer_output_pin_o,
   output logic timer_output_pin_oe_o,
   // sticky match flags
   output logic match_a_flag_o,
   output logic match_p_flag_o
);

   // p value to counter span, zero meaning a full 1024 counts
   function automatic logic [10:0] ctm_p_span(input logic [2:0] p);
      ctm_p_span = (p == 3'h0) ? `CTM_FULL_SPAN : {1'b0, p, 7'h00};
   endfunction

   // request bundle
   ctm_wb_req_t req;
   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

   // state
   logic [7:0] run_clock_ctrl;
   logic [7:0] mode_out_ctrl;
   logic [9:0] count;
   logic [9:0] match_a_value;
   logic [7:0] low_buf;
   logic [1:0] flags;
   logic cm_level;
   logic on_q;
   logic [5:0] prescale;
   logic ext_s1, ext_s2, ext_s3, ext_lvl, ext_prev;
   logic ack;
   logic [31:0] rdata;
   logic pin_q, pin_oe_q;

   // control fields
   wire logic pause = run_clock_ctrl[`CTM_PAUSE_POS];
   wire logic timer_on = run_clock_ctrl[`CTM_ON_POS];
   wire logic [2:0] match_p_value = run_clock_ctrl[`CTM_MATCH_P_MSB:`CTM_MATCH_P_LSB];
   wire ctm_clk_sel_t clk_sel = ctm_clk_sel_t'(run_clock_ctrl[`CTM_CLKSEL_MSB:`CTM_CLKSEL_LSB]);
   wire ctm_mode_t mode = ctm_mode_t'(mode_out_ctrl[`CTM_MODE_MSB:`CTM_MODE_LSB]);
   wire logic [1:0] pin_act = mode_out_ctrl[`CTM_PINACT_MSB:`CTM_PINACT_LSB];
   wire logic init_level = mode_out_ctrl[`CTM_INIT_LEVEL_POS];
   wire logic invert = mode_out_ctrl[`CTM_INVERT_POS];
   wire logic swap = mode_out_ctrl[`CTM_SWAP_POS];
   wire logic clr_src = mode_out_ctrl[`CTM_CLR_SRC_POS];
   wire logic is_pwm = (mode == CTM_MODE_PWM);

   // bus decode
   wire logic access = req.cyc && req.stb && !ack;
   // a write lands at the edge at which the master sees ack, request still held
   wire logic wr = req.cyc && req.stb && ack && req.we && req.sel[0];
   wire logic rd = access && !req.we;
   wire logic hit_c0 = (req.adr == `CTM_ADR_RUN_CLOCK_CTRL);
   wire logic hit_c1 = (req.adr == `CTM_ADR_MODE_OUT_CTRL);
   wire logic hit_cl = (req.adr == `CTM_ADR_COUNT_LOW);
   wire logic hit_ch = (req.adr == `CTM_ADR_COUNT_HIGH);
   wire logic hit_al = (req.adr == `CTM_ADR_MATCH_A_LOW);
   wire logic hit_ah = (req.adr == `CTM_ADR_MATCH_A_HIGH);
   wire logic hit_fl = (req.adr == `CTM_ADR_FLAGS);

   // read mux; low bytes come from the shared buffer
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (hit_c0) next_rdata = {24'h00_0000, run_clock_ctrl};
      if (hit_c1) next_rdata = {24'h00_0000, mode_out_ctrl};
      if (hit_cl || hit_al) next_rdata = {24'h00_0000, low_buf};
      if (hit_ch) next_rdata = {30'h0000_0000, count[9:8]};
      if (hit_ah) next_rdata = {30'h0000_0000, match_a_value[9:8]};
      if (hit_fl) next_rdata = {30'h0000_0000, flags};
   end

   // wishbone answer one cycle after the request, dropped the next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         ack <= access;
         rdata <= rd ? next_rdata : 32'h0000_0000;
      end
   end

   // shared low-byte buffer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low_buf <= 8'h00;
      end else if (wr && hit_al) begin
         low_buf <= req.dat[7:0];
      end else if (rd && hit_ch) begin
         low_buf <= count[7:0];
      end else if (rd && hit_ah) begin
         low_buf <= match_a_value[7:0];
      end
   end

   // control registers and match A pair
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_clock_ctrl <= `CTM_RUN_CLOCK_CTRL_RST;
         mode_out_ctrl <= `CTM_MODE_OUT_CTRL_RST;
         match_a_value <= `CTM_MATCH_A_RST;
      end else if (wr) begin
         if (hit_c0) run_clock_ctrl <= req.dat[7:0];
         if (hit_c1) mode_out_ctrl <= req.dat[7:0];
         if (hit_ah) match_a_value <= {req.dat[1:0], low_buf};
      end
   end

   // external clock pin: three flops, level taken when the last two agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
         ext_lvl <= 1'b0;
         ext_prev <= 1'b0;
      end else begin
         ext_s1 <= external_clock_pin_i;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
         if (ext_s2 == ext_s3) ext_lvl <= ext_s3;
         ext_prev <= ext_lvl;
      end
   end

   // internal divider for the divided clock choices
   always_ff @(posedge clk_i) begin
      if (rst_i) prescale <= 6'h00;
      else prescale <= prescale + 6'h01;
   end

   // counter tick by clock select
   logic tick;
   always_comb begin
      unique case (clk_sel)
         CTM_CK_SYS_DIV4: tick = (prescale[1:0] == 2'h3);
         CTM_CK_SYS: tick = 1'b1;
         CTM_CK_H_DIV16: tick = (prescale[3:0] == 4'hf);
         CTM_CK_H_DIV64: tick = (prescale == 6'h3f);
         CTM_CK_SUB_A, CTM_CK_SUB_B: tick = sub_clock_tick_i;
         CTM_CK_EXT_RISE: tick = ext_lvl && !ext_prev;
         CTM_CK_EXT_FALL: tick = !ext_lvl && ext_prev;
      endcase
   end

   // comparators; a match is the tick at which the count reaches the value
   wire logic on_rise = timer_on && !on_q;
   wire logic step = timer_on && !pause && tick && !on_rise;
   wire logic [10:0] count_inc = {1'b0, count} + 11'h001;
   wire logic [10:0] p_span = ctm_p_span(match_p_value);
   wire logic [10:0] a_span = (match_a_value == 10'h000) ? `CTM_FULL_SPAN : {1'b0, match_a_value};
   wire logic a_hit = (match_a_value != 10'h000) && (count_inc == {1'b0, match_a_value});
   wire logic p_hit = (count_inc == p_span);
   wire logic [10:0] period = swap ? a_span : p_span;
   wire logic [10:0] duty = swap ? p_span : {1'b0, match_a_value};
   wire logic pwm_active = (duty >= period) || ({1'b0, count} < duty);
   wire logic pwm_clr = (count_inc == period);
   wire logic cmp_clr = clr_src ? a_hit : p_hit;
   wire logic clr = is_pwm ? pwm_clr : cmp_clr;
   wire logic set_a = step && a_hit;
   wire logic set_p = step && p_hit && (is_pwm || !clr_src);

   // counter: cleared on timer-on rise, held when off or paused
   logic [9:0] next_count;
   always_comb begin
      next_count = count;
      if (on_rise) next_count = `CTM_COUNT_RST;
      else if (step) next_count = clr ? `CTM_COUNT_RST : count_inc[9:0];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count <= `CTM_COUNT_RST;
         on_q <= 1'b0;
      end else begin
         count <= next_count;
         on_q <= timer_on;
      end
   end

   // sticky flags, write one to clear, a set in the same cycle wins
   wire logic [1:0] flag_clr = (wr && hit_fl) ? req.dat[1:0] : 2'h0;
   wire logic [1:0] flag_set = {set_p, set_a};
   always_ff @(posedge clk_i) begin
      if (rst_i) flags <= `CTM_FLAGS_RST;
      else flags <= (flags & ~flag_clr) | flag_set;
   end

   // compare-mode pin level; only a match A event or the timer-on rise moves it
   logic next_cm_level;
   always_comb begin
      next_cm_level = cm_level;
      if (on_rise) begin
         next_cm_level = init_level;
      end else if (set_a && !is_pwm) begin
         unique case (pin_act)
            2'b00: next_cm_level = cm_level;
            2'b01: next_cm_level = 1'b0;
            2'b10: next_cm_level = 1'b1;
            2'b11: next_cm_level = !cm_level;
         endcase
      end
   end

   // pwm pin: forced inactive, forced active or waveform; active level from initial bit
   wire logic pwm_on = (pin_act == 2'b01) || ((pin_act == 2'b10) && pwm_active);
   wire logic pwm_level = pwm_on ? init_level : !init_level;
   wire logic next_pin = (is_pwm ? pwm_level : cm_level) ^ invert;
   wire logic next_oe = (mode != CTM_MODE_TC);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cm_level <= 1'b0;
         pin_q <= 1'b0;
         pin_oe_q <= 1'b0;
      end else begin
         cm_level <= next_cm_level;
         pin_q <= next_oe ? next_pin : 1'b0;
         pin_oe_q <= next_oe;
      end
   end

   // outputs straight from flops
   assign wb_ack_o = ack;
   assign wb_dat_o = rdata;
   assign timer_output_pin_o = pin_q;
   assign timer_output_pin_oe_o = pin_oe_q;
   assign match_a_flag_o = flags[`CTM_FLAG_A_POS];
   assign match_p_flag_o = flags[`CTM_FLAG_P_POS];

   // checks
   property p_on_rise_clears;
      @(posedge clk_i) disable iff (rst_i)
      on_rise |=> (count == 10'h000);
   endproperty
   a_on_rise_clears: assert property (p_on_rise_clears) else $error("counter not cleared by timer-on rise");

   property p_off_holds;
      @(posedge clk_i) disable iff (rst_i)
      (!timer_on && on_q) ##1 !timer_on |-> $stable(count);
   endproperty
   a_off_holds: assert property (p_off_holds) else $error("counter moved while off");

   property p_pause_holds;
      @(posedge clk_i) disable iff (rst_i)
      (timer_on && on_q && pause) |=> (count == $past(count));
   endproperty
   a_pause_holds: assert property (p_pause_holds) else $error("counter moved while paused");

   property p_no_p_flag;
      @(posedge clk_i) disable iff (rst_i)
      (!is_pwm && clr_src && !flags[1]) |=> !flags[1];
   endproperty
   a_no_p_flag: assert property (p_no_p_flag) else $error("match P flag raised with clear on A");

   property p_a_zero_no_flag;
      @(posedge clk_i) disable iff (rst_i)
      (match_a_value == 10'h000 && !flags[0]) |=> !flags[0];
   endproperty
   a_a_zero_no_flag: assert property (p_a_zero_no_flag) else $error("match A flag with zero value");

   property p_p_clear;
      @(posedge clk_i) disable iff (rst_i)
      (step && !is_pwm && !clr_src && p_hit) |=> (count == 10'h000) && flags[1];
   endproperty
   a_p_clear: assert property (p_p_clear) else $error("match P did not clear and flag");

   property p_cmp_high;
      @(posedge clk_i) disable iff (rst_i)
      (set_a && mode == CTM_MODE_CMP && pin_act == 2'b10 && !invert) ##1 (!on_rise && !invert && !is_pwm)
         |=> timer_output_pin_o;
   endproperty
   a_cmp_high: assert property (p_cmp_high) else $error("pin not driven high on match A");

   property p_restart_level;
      @(posedge clk_i) disable iff (rst_i)
      on_rise |=> (cm_level == $past(init_level));
   endproperty
   a_restart_level: assert property (p_restart_level) else $error("pin level not restored at start");

   property p_tc_undriven;
      @(posedge clk_i) disable iff (rst_i)
      (mode == CTM_MODE_TC) |=> !timer_output_pin_oe_o;
   endproperty
   a_tc_undriven: assert property (p_tc_undriven) else $error("pin driven in timer/counter mode");

   property p_pwm_forced;
      @(posedge clk_i) disable iff (rst_i)
      (is_pwm && pin_act == 2'b01) |=> (timer_output_pin_o == $past(init_level ^ invert));
   endproperty
   a_pwm_forced: assert property (p_pwm_forced) else $error("pwm forced active level wrong");

   property p_count_high_zero;
      @(posedge clk_i) disable iff (rst_i)
      (rd && hit_ch) |=> wb_ack_o && (wb_dat_o[31:2] == 30'h0000_0000);
   endproperty
   a_count_high_zero: assert property (p_count_high_zero) else $error("count high upper bits not zero");

   property p_a_clear;
      @(posedge clk_i) disable iff (rst_i)
      (step && !is_pwm && clr_src && a_hit) |=> (count == 10'h000) && flags[0];
   endproperty
   a_a_clear: assert property (p_a_clear) else $error("match A did not clear and flag");

   property p_cm_pin_still;
      @(posedge clk_i) disable iff (rst_i)
      (!is_pwm && !set_a && !on_rise) |=> (cm_level == $past(cm_level));
   endproperty
   a_cm_pin_still: assert property (p_cm_pin_still) else $error("compare level moved without match A");

   property p_pwm_period_clear;
      @(posedge clk_i) disable iff (rst_i)
      (step && is_pwm && pwm_clr) |=> (count == 10'h000);
   endproperty
   a_pwm_period_clear: assert property (p_pwm_period_clear) else $error("pwm period did not clear counter");

   property p_div4_hold;
      @(posedge clk_i) disable iff (rst_i)
      (timer_on && on_q && clk_sel == CTM_CK_SYS_DIV4 && prescale[1:0] != 2'h3) |=> $stable(count);
   endproperty
   a_div4_hold: assert property (p_div4_hold) else $error("counter stepped off the divided tick");

endmodule
`default_nettype wire

/* hw/ctm_regs.svh */
// register offsets, field positions, reset values and counter span figures of the compact timer
// assumes word-aligned classic wishbone access, one register per 32-bit word
`ifndef CTM_REGS_SVH
`define CTM_REGS_SVH

// byte addresses of the registers
`define CTM_ADR_RUN_CLOCK_CTRL 8'h00
`define CTM_ADR_MODE_OUT_CTRL 8'h04
`define CTM_ADR_COUNT_LOW 8'h08
`define CTM_ADR_COUNT_HIGH 8'h0c
`define CTM_ADR_MATCH_A_LOW 8'h10
`define CTM_ADR_MATCH_A_HIGH 8'h14
`define CTM_ADR_FLAGS 8'h18

// reset values
`define CTM_RUN_CLOCK_CTRL_RST 8'h00
`define CTM_MODE_OUT_CTRL_RST 8'h00
`define CTM_COUNT_RST 10'h000
`define CTM_MATCH_A_RST 10'h000
`define CTM_FLAGS_RST 2'h0

// timer_run_clock_control fields
`define CTM_PAUSE_POS 7
`define CTM_CLKSEL_MSB 6
`define CTM_CLKSEL_LSB 4
`define CTM_ON_POS 3
`define CTM_MATCH_P_MSB 2
`define CTM_MATCH_P_LSB 0

// timer_mode_output_control fields
`define CTM_MODE_MSB 7
`define CTM_MODE_LSB 6
`define CTM_PINACT_MSB 5
`define CTM_PINACT_LSB 4
`define CTM_INIT_LEVEL_POS 3
`define CTM_INVERT_POS 2
`define CTM_SWAP_POS 1
`define CTM_CLR_SRC_POS 0

// flag register fields
`define CTM_FLAG_A_POS 0
`define CTM_FLAG_P_POS 1

// counter span figures
`define CTM_P_STEP_SHIFT 7
`define CTM_FULL_SPAN 11'h400

`endif

/* hw/ctm_pkg.sv */
// types shared by the compact timer design
// assumes the constants header is included by the design file
package ctm_pkg;

   // operating mode codes
   typedef enum logic [1:0] {
      CTM_MODE_CMP = 2'b00,
      CTM_MODE_UNDEF = 2'b01,
      CTM_MODE_PWM = 2'b10,
      CTM_MODE_TC = 2'b11
   } ctm_mode_t;

   // counter clock sources
   typedef enum logic [2:0] {
      CTM_CK_SYS_DIV4 = 3'h0,
      CTM_CK_SYS = 3'h1,
      CTM_CK_H_DIV16 = 3'h2,
      CTM_CK_H_DIV64 = 3'h3,
      CTM_CK_SUB_A = 3'h4,
      CTM_CK_SUB_B = 3'h5,
      CTM_CK_EXT_RISE = 3'h6,
      CTM_CK_EXT_FALL = 3'h7
   } ctm_clk_sel_t;

   // one wishbone request as seen by the slave
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } ctm_wb_req_t;

endpackage

/* verification/ctm_timer_test.sv */
// self-checking bench of the compact timer: bus pairs, compare, timer/counter, pwm, pause
// assumes the design, its package and its header compiled first, one 250 MHz clock
`timescale 1ns/1ns
`default_nettype none
`include "ctm_regs.svh"
module compact_timer_modes_control_test;
   import ctm_pkg::*;
   // bench signals
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack, pin, oe, fa, fp;
   logic ext = 1'b0;
   logic sub = 1'b0;
   logic [15:0] lfsr = 16'h0021;
   int num_errors = 0;
   int comparisons = 0;
   // pwm cases: pin action, initial level, invert, swap, match p, match a
   logic [17:0] pwm_tab [6] = '{{2'b10, 3'b100, 3'h1, 10'd32}, {2'b10, 3'b010, 3'h1, 10'd100},
      {2'b10, 3'b001, 3'h1, 10'd512}, {2'b10, 3'b100, 3'h1, 10'd200},
      {2'b00, 3'b110, 3'h2, 10'd32}, {2'b01, 3'b000, 3'h2, 10'd32}};

   ctm_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .external_clock_pin_i(ext), .sub_clock_tick_i(sub), .timer_output_pin_o(pin),
      .timer_output_pin_oe_o(oe), .match_a_flag_o(fa), .match_p_flag_o(fp));

   // clock, random external and sub clock inputs
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      lfsr <= lfsr_next(lfsr);
      ext <= lfsr[1];
      sub <= lfsr[9];
   end

   function logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // compare-mode level after a match a
   function logic cmp_lvl(input logic [1:0] pa, input logic init);
      case (pa)
         2'b00: return init;
         2'b01: return 1'b0;
         2'b10: return 1'b1;
         default: return ~init;
      endcase
   endfunction
   // active cycles expected in a 512-cycle window
   function int pwm_exp(input logic [1:0] pa, input logic swap, input logic [2:0] p, input logic [9:0] a);
      int pv, per, duty;
      pv = (p == 3'h0) ? 1024 : 128 * int'(p);
      per = swap ? int'(a) : pv;
      duty = swap ? pv : int'(a);
      if (pa == 2'b00) return 0;
      if (pa == 2'b01 || duty >= per) return 512;
      return duty * 512 / per;
   endfunction
   // counter steps over 384 cycles for the system and divided clock choices
   function int steps_exp(input logic [2:0] cs);
      case (cs)
         3'h0: return 384 / 4;
         3'h1: return 384;
         3'h2: return 384 / 16;
         default: return 384 / 64;
      endcase
   endfunction

   // compare tasks
   task chk_bit(input string nm, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask
   task chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chk_num(input string nm, input int e, input int g);
      comparisons++;
      if (g != e) begin
         num_errors++;
         $display("BAD %s expected %0d seen %0d", nm, e, g);
      end
   endtask

   // one classic wishbone cycle, held until ack
   task wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
      chk_bit("bus ack drop", 1'b0, ack);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask
   // high byte first, then the buffered low byte
   task rd_pair(input logic [7:0] hi, output logic [9:0] v);
      logic [7:0] h, l;
      wb(1'b0, hi, 8'h00, h);
      wb(1'b0, hi - 8'h04, 8'h00, l);
      chk_val("high byte upper bits", 16'h0, {8'h0, h & 8'hfc});
      v = {h[1:0], l};
   endtask
   task setup(input logic [7:0] mode, input logic [9:0] a, input logic [7:0] run);
      wr(`CTM_ADR_RUN_CLOCK_CTRL, 8'h10);
      wr(`CTM_ADR_FLAGS, 8'h03);
      wr(`CTM_ADR_MODE_OUT_CTRL, mode);
      wr(`CTM_ADR_MATCH_A_LOW, a[7:0]);
      wr(`CTM_ADR_MATCH_A_HIGH, {6'h0, a[9:8]});
      wr(`CTM_ADR_RUN_CLOCK_CTRL, run);
   endtask
   task wait_hi(input string nm, input logic sel_p, input int lim);
      int n;
      n = 0;
      while ((sel_p ? fp : fa) !== 1'b1 && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      chk_bit(nm, 1'b1, sel_p ? fp : fa);
   endtask
   task wrap_up();
      if (num_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // main sequence
   initial begin
      logic [9:0] v, c1, a;
      logic [7:0] q;
      logic [1:0] pa;
      logic init, inv, swap;
      logic [2:0] p;
      int n;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, `CTM_ADR_MODE_OUT_CTRL, 8'h00, q);
      chk_val("mode control reset", 16'h0, {8'h0, q});
      wb(1'b0, 8'h1c, 8'h00, q);
      chk_val("unmapped read", 16'h0, {8'h0, q});
      v = lfsr[9:0];
      wr(`CTM_ADR_MATCH_A_LOW, v[7:0]);
      wr(`CTM_ADR_MATCH_A_HIGH, {6'h0, v[9:8]});
      wr(`CTM_ADR_COUNT_LOW, 8'hff);
      rd_pair(`CTM_ADR_MATCH_A_HIGH, c1);
      chk_val("match a readback", {6'h0, v}, {6'h0, c1});
      rd_pair(`CTM_ADR_COUNT_HIGH, c1);
      chk_val("count read only", 16'h0, {6'h0, c1});
      // compare mode, clear on a, every pin action and initial level
      for (int k = 0; k < 8; k++) begin
         pa = k[1:0];
         init = k[2];
         inv = lfsr[3];
         setup({2'b00, pa, init, inv, 2'b01}, 10'h12c, 8'h19);
         repeat (2) @(posedge clk_i);
         chk_bit("pin enable", 1'b1, oe);
         chk_bit("pin initial", init ^ inv, pin);
         wait_hi("match a flag", 1'b0, 400);
         chk_bit("match p flag", 1'b0, fp);
         repeat (2) @(posedge clk_i);
         chk_bit("pin after match", cmp_lvl(pa, init) ^ inv, pin);
      end
      // clear on p: both flags, count kept below p
      setup(8'h00, 10'd40, 8'h19);
      wait_hi("match a flag", 1'b0, 60);
      wait_hi("match p flag", 1'b1, 200);
      rd_pair(`CTM_ADR_COUNT_HIGH, v);
      chk_bit("count below p", 1'b1, v < 10'd128);
      // match a zero runs to overflow with no flags
      setup(8'h01, 10'h000, 8'h19);
      repeat (1100) @(posedge clk_i);
      chk_bit("match a flag", 1'b0, fa);
      chk_bit("match p flag", 1'b0, fp);
      // timer/counter mode leaves the pin undriven
      setup(8'hc1, 10'd40, 8'h19);
      repeat (2) @(posedge clk_i);
      chk_bit("pin enable", 1'b0, oe);
      wait_hi("match a flag", 1'b0, 60);
      // clock select: steps counted between two samples 384 cycles apart
      for (int k = 0; k < 4; k++) begin
         setup(8'h01, 10'h3e8, {1'b0, k[2:0], 4'h8});
         rd_pair(`CTM_ADR_COUNT_HIGH, c1);
         repeat (378) @(posedge clk_i);
         rd_pair(`CTM_ADR_COUNT_HIGH, v);
         chk_num("count steps", steps_exp(k[2:0]), int'(v - c1));
      end
      // pause, resume, stop and restart
      setup(8'h01, 10'h3e8, 8'h18);
      wr(`CTM_ADR_RUN_CLOCK_CTRL, 8'h98);
      rd_pair(`CTM_ADR_COUNT_HIGH, c1);
      repeat (30) @(posedge clk_i);
      rd_pair(`CTM_ADR_COUNT_HIGH, v);
      chk_val("paused count", {6'h0, c1}, {6'h0, v});
      wr(`CTM_ADR_RUN_CLOCK_CTRL, 8'h18);
      repeat (30) @(posedge clk_i);
      rd_pair(`CTM_ADR_COUNT_HIGH, v);
      chk_bit("count resumes", 1'b1, v > c1);
      wr(`CTM_ADR_RUN_CLOCK_CTRL, 8'h10);
      rd_pair(`CTM_ADR_COUNT_HIGH, c1);
      repeat (30) @(posedge clk_i);
      rd_pair(`CTM_ADR_COUNT_HIGH, v);
      chk_val("stopped count", {6'h0, c1}, {6'h0, v});
      wr(`CTM_ADR_RUN_CLOCK_CTRL, 8'h18);
      rd_pair(`CTM_ADR_COUNT_HIGH, v);
      chk_bit("count cleared", 1'b1, v < c1);
      // pwm cases, active cycles over a 512-cycle window
      for (int k = 0; k < 6; k++) begin
         {pa, init, inv, swap, p, a} = pwm_tab[k];
         if (k == 0)
            a = {3'h0, lfsr[6:0]};
         setup({2'b10, pa, init, inv, swap, k[0]}, a, {5'h03, p});
         repeat (8) @(posedge clk_i);
         n = 0;
         repeat (512) begin
            @(posedge clk_i);
            if (pin === (init ^ inv))
               n++;
         end
         chk_num("pwm active cycles", pwm_exp(pa, swap, p, a), n);
      end
      chk_bit("pwm match a flag", 1'b1, fa);
      chk_bit("pwm match p flag", 1'b1, fp);
      wrap_up();
   end

   // watchdog against a hung bus or flag wait
   initial begin
      repeat (40000) @(posedge clk_i);
      num_errors++;
      wrap_up();
   end
endmodule
`default_nettype wire
